// file: design/lsd_defines.svh
// Behaviour
// RULE_01 - noise count snapshot read captures the noise timer in bits 0-6
// RULE_02 - noise snapshot writes store nothing and raise write reject
// RULE_03 - noise prescale snapshot read captures the full 8-bit prescaler
// RULE_04 - state main counter steps per 80 ns tick when prescaler is zero
// RULE_05 - state pair reaches zero after ((P+1)*M+P) ticks of 80 ns
// RULE_06 - both state counters zero in a qualifying state reloads both
// RULE_07 - line change into a qualifying state reloads both state counters
// RULE_08 - writing either state threshold reloads both state counters
// RULE_09 - state prescaler at zero reloads alone from its threshold
// RULE_10 - active, noise or unknown line state freezes both state counters
// RULE_11 - 8-bit state prescaler steps down per tick in qualifying states
// RULE_12 - state threshold holds 7 bits, bit 7 reads zero, ignores writes
// RULE_13 - state prescale threshold holds 8 bits, lsb in bit 0
// RULE_14 - noise main counter steps once per (prescale threshold + 1) ticks
// RULE_15 - both noise counters zero in a noise-class state reloads both
// RULE_16 - change into a noise-class state does not reload noise counters
// RULE_17 - captured snapshot stays stable for the whole read
`ifndef LSD_DEFINES_SVH
`define LSD_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define LSD_ADDR_W          5
`define LSD_OFS_NOISE_THR   5'h0d
`define LSD_OFS_NOISE_PTHR  5'h0e
`define LSD_OFS_NOISE_SNAP  5'h0f
`define LSD_OFS_NPRE_SNAP   5'h10
`define LSD_OFS_STATE_THR   5'h11
`define LSD_OFS_STATE_PTHR  5'h12

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define LSD_MAIN_W          7
`define LSD_PRE_W           8
`define LSD_DATA_W          8
`define LSD_RESERVED_BIT    7
`define LSD_MAIN_THR_RST    7'h00
`define LSD_PRE_THR_RST     8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LSD_CLK_NS          10
`define LSD_TICK_NS         80
`define LSD_TICK_CYC        ((`LSD_TICK_NS + `LSD_CLK_NS - 1) / `LSD_CLK_NS)

`endif

// file: design/lsd_pkg.sv
`include "lsd_defines.svh"

package lsd_pkg;

   // -------------------------------------------------------------
   // received line states
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      LSD_LS_ACTIVE  = 3'b000,
      LSD_LS_IDLE    = 3'b001,
      LSD_LS_HALT    = 3'b010,
      LSD_LS_MASTER  = 3'b011,
      LSD_LS_QUIET   = 3'b100,
      LSD_LS_NSD     = 3'b101,
      LSD_LS_NOISE   = 3'b110,
      LSD_LS_UNKNOWN = 3'b111
   } lsd_line_state_t;

   // -------------------------------------------------------------
   // control bus request
   // -------------------------------------------------------------
   typedef struct packed {
      logic                     sel;
      logic                     wr;
      logic [`LSD_ADDR_W-1:0]   addr;
      logic [`LSD_DATA_W-1:0]   wdata;
   } lsd_cb_req_t;

   // halt, idle, master, quiet, no signal detect
   function automatic logic lsd_is_state_class(lsd_line_state_t ls);
      case (ls)
         LSD_LS_HALT, LSD_LS_IDLE, LSD_LS_MASTER,
         LSD_LS_QUIET, LSD_LS_NSD: lsd_is_state_class = 1'b1;
         default: lsd_is_state_class = 1'b0;
      endcase
   endfunction

endpackage

// file: design/lsd_tick_gen.sv
`timescale 1ns/10ps
`include "lsd_defines.svh"

// ----------------------------------------------------------------
// one pulse per symbol period
// ----------------------------------------------------------------
module lsd_tick_gen #(
   parameter int TICK_CYC = `LSD_TICK_CYC
) (
   input  wire logic mclk,
   input  wire logic nrst,
   output logic      tick
);

   localparam int CW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;

   logic [CW-1:0] cnt_r;

   initial begin
      if (TICK_CYC < 1)
         $error("tick period below one cycle");
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= '0;
         tick  <= 1'b0;
      end else if (cnt_r == CW'(TICK_CYC - 1)) begin
         cnt_r <= '0;
         tick  <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 1'b1;
         tick  <= 1'b0;
      end
   end

endmodule

// file: design/lsd_timer_pair.sv
`timescale 1ns/10ps
`include "lsd_defines.svh"

// ----------------------------------------------------------------
// main counter with prescaler, both counting down
// ----------------------------------------------------------------
module lsd_timer_pair #(
   parameter int MAIN_W = `LSD_MAIN_W,
   parameter int PRE_W  = `LSD_PRE_W
) (
   input  wire logic              mclk,
   input  wire logic              nrst,
   input  wire logic              tick,
   input  wire logic              count_en,
   input  wire logic              reload,
   input  wire logic [MAIN_W-1:0] main_thr,
   input  wire logic [PRE_W-1:0]  pre_thr,
   output logic      [MAIN_W-1:0] main_cnt,
   output logic      [PRE_W-1:0]  pre_cnt
);

   initial begin
      if (MAIN_W < 1 || PRE_W < 1 || MAIN_W > `LSD_DATA_W ||
          PRE_W > `LSD_DATA_W)
         $error("counter width not servable");
   end

   default clocking dflt_clk @(posedge mclk);
   endclocking

   default disable iff (!nrst);

   logic step;
   assign step = tick && count_en;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         main_cnt <= '0;
         pre_cnt  <= '0;
      end else if (reload) begin
         main_cnt <= main_thr;
         pre_cnt  <= pre_thr;
      end else if (step) begin
         if (pre_cnt == '0) begin
            pre_cnt <= pre_thr;                      // RULE_09
            if (main_cnt != '0)
               main_cnt <= main_cnt - 1'b1;          // RULE_04 RULE_14
         end else begin
            pre_cnt <= pre_cnt - 1'b1;               // RULE_11
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_PRE_RELOAD: assert property (  // RULE_09
      step && !reload && pre_cnt == '0 |=> pre_cnt == $past(pre_thr))
      else $error("prescaler did not reload at zero");

   AST_MAIN_STEP: assert property (  // RULE_04
      step && !reload && pre_cnt == '0 && main_cnt != '0
      |=> main_cnt == $past(main_cnt) - 1'b1)
      else $error("main counter missed its step");

   AST_PRE_STEP: assert property (  // RULE_11
      step && !reload && pre_cnt != '0
      |=> pre_cnt == $past(pre_cnt) - 1'b1 && $stable(main_cnt))
      else $error("prescaler missed its step");

endmodule

// file: design/lsd_line_state_timers.sv
`timescale 1ns/10ps
`include "lsd_defines.svh"

// ----------------------------------------------------------------
// line state duration and noise timers with control bus registers
// ----------------------------------------------------------------
module lsd_line_state_timers #(
   parameter int MAIN_W   = `LSD_MAIN_W,
   parameter int PRE_W    = `LSD_PRE_W,
   parameter int TICK_CYC = `LSD_TICK_CYC
) (
   input  wire logic                    mclk,
   input  wire logic                    nrst,
   input  wire lsd_pkg::lsd_cb_req_t    cb_req,
   input  wire lsd_pkg::lsd_line_state_t line_state,
   output logic [`LSD_DATA_W-1:0]       cb_rdata_r,
   output logic                         cb_ack_r,
   output logic                         write_reject_r,
   output logic                         state_expired_r,
   output logic                         noise_expired_r,
   output logic [MAIN_W-1:0]            state_count,
   output logic [PRE_W-1:0]             state_prescale_count
);

   initial begin
      if (MAIN_W != `LSD_MAIN_W || PRE_W != `LSD_PRE_W)
         $error("register layout fixes the counter widths");
      if (TICK_CYC < 1)
         $error("tick period below one cycle");
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [MAIN_W-1:0]        state_main_threshold_r;
   logic [PRE_W-1:0]         state_prescale_threshold_r;
   logic [MAIN_W-1:0]        noise_main_threshold_r;
   logic [PRE_W-1:0]         noise_prescale_threshold_r;
   logic [MAIN_W-1:0]        noise_cnt;
   logic [PRE_W-1:0]         noise_pre;
   lsd_pkg::lsd_line_state_t prev_ls_r;
   logic                     noise_linestate_change_flag_r;
   logic                     state_wr_reload_r;
   logic                     noise_wr_reload_r;
   logic                     tick;
   logic                     rd;
   logic                     wr;
   logic                     ls_change;
   logic                     in_state_class;
   logic                     state_zero;
   logic                     noise_zero;
   logic                     state_reload;
   logic                     noise_reload;

   default clocking dflt_clk @(posedge mclk);
   endclocking

   default disable iff (!nrst);

   function automatic logic hit(input lsd_pkg::lsd_cb_req_t req,
                                input logic [`LSD_ADDR_W-1:0] ofs);
      hit = req.sel && (req.addr == ofs);
   endfunction

   assign rd             = cb_req.sel && !cb_req.wr;
   assign wr             = cb_req.sel && cb_req.wr;
   assign ls_change      = (line_state != prev_ls_r);
   assign in_state_class = lsd_pkg::lsd_is_state_class(line_state);
   assign state_zero     = (state_count == '0) &&
                           (state_prescale_count == '0);
   assign noise_zero     = (noise_cnt == '0) && (noise_pre == '0);

   // ----------------------------------------------------------------
   // reload decisions
   // ----------------------------------------------------------------
   assign state_reload = state_wr_reload_r ||                 // RULE_08
                         (ls_change && in_state_class) ||     // RULE_07
                         (tick && in_state_class && state_zero); // RULE_06
   assign noise_reload = noise_wr_reload_r ||                 // RULE_16
                         in_state_class ||
                         (tick && !in_state_class && noise_zero); // RULE_15

   // ----------------------------------------------------------------
   // counters
   // ----------------------------------------------------------------
   lsd_tick_gen #(
      .TICK_CYC (TICK_CYC)
   ) u_tick (
      .mclk (mclk),
      .nrst (nrst),
      .tick (tick)
   );

   lsd_timer_pair #(
      .MAIN_W (MAIN_W),
      .PRE_W  (PRE_W)
   ) u_state (
      .mclk     (mclk),
      .nrst     (nrst),
      .tick     (tick),
      .count_en (in_state_class),                       // RULE_10
      .reload   (state_reload),
      .main_thr (state_main_threshold_r),
      .pre_thr  (state_prescale_threshold_r),
      .main_cnt (state_count),
      .pre_cnt  (state_prescale_count)
   );

   lsd_timer_pair #(
      .MAIN_W (MAIN_W),
      .PRE_W  (PRE_W)
   ) u_noise (
      .mclk     (mclk),
      .nrst     (nrst),
      .tick     (tick),
      .count_en (!in_state_class),                      // RULE_14
      .reload   (noise_reload),
      .main_thr (noise_main_threshold_r),
      .pre_thr  (noise_prescale_threshold_r),
      .main_cnt (noise_cnt),
      .pre_cnt  (noise_pre)
   );

   // ----------------------------------------------------------------
   // line state history and change flag
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         prev_ls_r <= lsd_pkg::LSD_LS_UNKNOWN;
      else
         prev_ls_r <= line_state;
   end

   // change into noise class: counters run on, flag is set
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         noise_linestate_change_flag_r <= 1'b0;
      else if (ls_change && !in_state_class)
         noise_linestate_change_flag_r <= 1'b1;         // RULE_16
      else if (rd && hit(cb_req, `LSD_OFS_NOISE_SNAP))
         noise_linestate_change_flag_r <= 1'b0;
   end

   // ----------------------------------------------------------------
   // threshold registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_main_threshold_r     <= `LSD_MAIN_THR_RST;
         state_prescale_threshold_r <= `LSD_PRE_THR_RST;
      end else if (wr && hit(cb_req, `LSD_OFS_STATE_THR)) begin
         state_main_threshold_r <= cb_req.wdata[MAIN_W-1:0]; // RULE_12
      end else if (wr && hit(cb_req, `LSD_OFS_STATE_PTHR)) begin
         state_prescale_threshold_r <= cb_req.wdata[PRE_W-1:0]; // RULE_13
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         noise_main_threshold_r     <= `LSD_MAIN_THR_RST;
         noise_prescale_threshold_r <= `LSD_PRE_THR_RST;
      end else if (wr && hit(cb_req, `LSD_OFS_NOISE_THR)) begin
         noise_main_threshold_r <= cb_req.wdata[MAIN_W-1:0];
      end else if (wr && hit(cb_req, `LSD_OFS_NOISE_PTHR)) begin
         noise_prescale_threshold_r <= cb_req.wdata[PRE_W-1:0];
      end
   end

   // reload one cycle later so the new threshold is used
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_wr_reload_r <= 1'b0;
         noise_wr_reload_r <= 1'b0;
      end else begin
         state_wr_reload_r <= wr && (hit(cb_req, `LSD_OFS_STATE_THR) ||
                                     hit(cb_req, `LSD_OFS_STATE_PTHR));
         noise_wr_reload_r <= wr && (hit(cb_req, `LSD_OFS_NOISE_THR) ||
                                     hit(cb_req, `LSD_OFS_NOISE_PTHR));
      end
   end

   // ----------------------------------------------------------------
   // bus answer and snapshots
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cb_ack_r   <= 1'b0;
         cb_rdata_r <= '0;
      end else begin
         cb_ack_r <= cb_req.sel;
         if (rd) begin                                  // RULE_17
            case (cb_req.addr)
               `LSD_OFS_NOISE_THR:
                  cb_rdata_r <= {1'b0, noise_main_threshold_r};
               `LSD_OFS_NOISE_PTHR:
                  cb_rdata_r <= noise_prescale_threshold_r;
               `LSD_OFS_NOISE_SNAP:
                  cb_rdata_r <= {noise_linestate_change_flag_r,
                                 noise_cnt};            // RULE_01
               `LSD_OFS_NPRE_SNAP:
                  cb_rdata_r <= noise_pre;              // RULE_03
               `LSD_OFS_STATE_THR:
                  cb_rdata_r <= {1'b0, state_main_threshold_r}; // RULE_12
               `LSD_OFS_STATE_PTHR:
                  cb_rdata_r <= state_prescale_threshold_r; // RULE_13
               default:
                  cb_rdata_r <= '0;
            endcase
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         write_reject_r <= 1'b0;
      else
         write_reject_r <= wr && (hit(cb_req, `LSD_OFS_NOISE_SNAP) ||
                                  hit(cb_req, `LSD_OFS_NPRE_SNAP)); // RULE_02
   end

   // ----------------------------------------------------------------
   // expiry events
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_expired_r <= 1'b0;
         noise_expired_r <= 1'b0;
      end else begin
         state_expired_r <= tick && in_state_class && state_zero; // RULE_05
         noise_expired_r <= tick && !in_state_class && noise_zero;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_rd(logic [`LSD_ADDR_W-1:0] ofs);
      rd && cb_req.addr == ofs;
   endsequence

   sequence s_wr(logic [`LSD_ADDR_W-1:0] ofs);
      wr && cb_req.addr == ofs;
   endsequence

   AST_NOISE_SNAP: assert property (  // RULE_01
      s_rd(`LSD_OFS_NOISE_SNAP)
      |=> cb_rdata_r[MAIN_W-1:0] == $past(noise_cnt))
      else $error("noise count snapshot wrong");

   AST_WR_REJECT: assert property (  // RULE_02
      (s_wr(`LSD_OFS_NOISE_SNAP) or s_wr(`LSD_OFS_NPRE_SNAP))
      |=> write_reject_r && $stable(noise_main_threshold_r) &&
          $stable(noise_prescale_threshold_r))
      else $error("snapshot write not rejected");

   AST_NPRE_SNAP: assert property (  // RULE_03
      s_rd(`LSD_OFS_NPRE_SNAP) |=> cb_rdata_r == $past(noise_pre))
      else $error("noise prescale snapshot wrong");

   AST_STATE_FREEZE: assert property (  // RULE_10
      !in_state_class && !state_reload
      |=> $stable(state_count) && $stable(state_prescale_count))
      else $error("state counters moved outside qualifying state");

   AST_STATE_EXPIRE: assert property (  // RULE_06
      tick && in_state_class && state_zero
      |=> state_count == $past(state_main_threshold_r) &&
          state_prescale_count == $past(state_prescale_threshold_r)
          && state_expired_r)
      else $error("state pair did not reload at expiry");

   AST_LS_RELOAD: assert property (  // RULE_07
      ls_change && in_state_class
      |=> state_count == $past(state_main_threshold_r) &&
          state_prescale_count == $past(state_prescale_threshold_r))
      else $error("state pair did not reload on line change");

   AST_THR_WR_RELOAD: assert property (  // RULE_08
      (s_wr(`LSD_OFS_STATE_THR) or s_wr(`LSD_OFS_STATE_PTHR)) ##1 1'b1
      |=> state_count == $past(state_main_threshold_r) &&
          state_prescale_count == $past(state_prescale_threshold_r))
      else $error("threshold write did not reload state pair");

   AST_STR_RES_BIT: assert property (  // RULE_12
      s_rd(`LSD_OFS_STATE_THR) |=> cb_rdata_r[`LSD_RESERVED_BIT] == 1'b0)
      else $error("reserved bit read as one");

   AST_STR_WRITE: assert property (  // RULE_12
      s_wr(`LSD_OFS_STATE_THR)
      |=> state_main_threshold_r == $past(cb_req.wdata[MAIN_W-1:0]))
      else $error("state threshold write lost");

   AST_STATE_PRESCALE_THRESHOLD_WRITE: assert property (  // RULE_13
      s_wr(`LSD_OFS_STATE_PTHR)
      |=> state_prescale_threshold_r == $past(cb_req.wdata))
      else $error("state prescale threshold write lost");

   AST_NOISE_EXPIRE: assert property (  // RULE_15
      tick && !in_state_class && noise_zero
      |=> noise_cnt == $past(noise_main_threshold_r) &&
          noise_pre == $past(noise_prescale_threshold_r))
      else $error("noise pair did not reload at expiry");

   AST_NOISE_RUN_ON: assert property (  // RULE_16
      ls_change && !in_state_class && !tick && !noise_wr_reload_r
      |=> $stable(noise_cnt) && $stable(noise_pre))
      else $error("noise pair reloaded on line change");

   AST_CHANGE_FLAG: assert property (  // RULE_16
      ls_change && !in_state_class |=> noise_linestate_change_flag_r)
      else $error("line change flag not set");

   AST_RDATA_HOLD: assert property (  // RULE_17
      !rd |=> $stable(cb_rdata_r))
      else $error("snapshot changed without a read");

endmodule

// file: tb/lsd_host_model.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------
// control bus master of the station manager
// ----------------------------------------------------------------
module lsd_host_model (
   input  wire logic           mclk,
   input  wire logic [7:0]     cb_rdata_r,
   input  wire logic           cb_ack_r,
   output lsd_pkg::lsd_cb_req_t cb_req
);
   initial cb_req = '0;

   // one access, taken at next edge, answer one cycle later
   task automatic access(input logic wr, input logic [4:0] addr,
                         input logic [7:0] wdata,
                         output logic [7:0] rdata, output logic ack);
      @(posedge mclk);
      #1;
      cb_req = {1'b1, wr, addr, wdata};
      @(posedge mclk);
      #1;
      rdata = cb_rdata_r;
      ack = cb_ack_r;
      // released data lines do not keep the last value
      cb_req = {1'b0, wr, addr, ~wdata};
   endtask
endmodule

// file: tb/lsd_line_state_timers_bench.sv
`timescale 1ns/10ps

module lsd_line_state_timers_bench;
   logic                     mclk;
   logic                     nrst;
   lsd_pkg::lsd_cb_req_t     cb_req;
   lsd_pkg::lsd_line_state_t line_state;
   logic [7:0]               cb_rdata_r;
   logic                     cb_ack_r;
   logic                     write_reject_r;
   logic                     state_expired_r;
   logic                     noise_expired_r;
   logic [6:0]               state_count;
   logic [7:0]               state_prescale_count;
   int                       error_cnt;
   int                       checks;
   int                       cyc;
   int                       n_exp;
   int                       steps;
   int                       gap;
   logic [7:0]               rd;
   logic [7:0]               v1;
   logic                     ak;
   logic [14:0]              cur;
   logic [14:0]              prv;
   logic [14:0]              expv;
   lsd_pkg::lsd_line_state_t run_ls [5] = '{lsd_pkg::LSD_LS_HALT,
      lsd_pkg::LSD_LS_IDLE, lsd_pkg::LSD_LS_MASTER,
      lsd_pkg::LSD_LS_QUIET, lsd_pkg::LSD_LS_NSD};
   lsd_pkg::lsd_line_state_t frz_ls [3] = '{lsd_pkg::LSD_LS_ACTIVE,
      lsd_pkg::LSD_LS_NOISE, lsd_pkg::LSD_LS_UNKNOWN};

   lsd_line_state_timers uut (
      .mclk                 (mclk),
      .nrst                 (nrst),
      .cb_req               (cb_req),
      .line_state           (line_state),
      .cb_rdata_r           (cb_rdata_r),
      .cb_ack_r             (cb_ack_r),
      .write_reject_r       (write_reject_r),
      .state_expired_r      (state_expired_r),
      .noise_expired_r      (noise_expired_r),
      .state_count          (state_count),
      .state_prescale_count (state_prescale_count)
   );

   lsd_host_model host (
      .mclk       (mclk),
      .cb_rdata_r (cb_rdata_r),
      .cb_ack_r   (cb_ack_r),
      .cb_req     (cb_req)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [14:0] seen,
                        input logic [14:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      host.access(1'b1, a, d, rd, ak);
      check("ack", ak, 1'b1);
   endtask

   task automatic rdc(input logic [4:0] a, input logic [7:0] e);
      host.access(1'b0, a, 8'h00, rd, ak);
      check("ack", ak, 1'b1);
      check("read data", rd, e);
   endtask

   task automatic cyc_wait(input int n);
      repeat (n) @(posedge mclk);
      #1;
      cur = {state_count, state_prescale_count};
   endtask

   task automatic end_of_test;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // clock and timeout
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         end_of_test();
      end
   end

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      nrst = 1'b0;
      line_state = lsd_pkg::LSD_LS_ACTIVE;
      repeat (20) @(posedge mclk);
      #1;
      nrst = 1'b1;
      rdc(5'h11, 8'h00);
      rdc(5'h12, 8'h00);
      rdc(5'h1f, 8'h00);
      wr(5'h11, 8'h82);
      check("reject", write_reject_r, 1'b0);
      rdc(5'h11, 8'h02);
      wr(5'h12, 8'h03);
      rdc(5'h12, 8'h03);
      cur = {state_count, state_prescale_count};
      check("write reload", cur, {7'h02, 8'h03});
      // count down to zero and reload in idle
      line_state = lsd_pkg::LSD_LS_IDLE;
      prv = cur;
      for (int i = 0; i < 150 && steps < 12; i++) begin
         cyc_wait(1);
         gap++;
         if (state_expired_r === 1'b1) n_exp++;
         if (cur !== prv) begin
            steps++;
            expv = (prv[7:0] == 8'h00) ? {prv[14:8] - 7'h01, 8'h03}
                                       : {prv[14:8], prv[7:0] - 8'h01};
            if (prv == 15'h0) expv = {7'h02, 8'h03};
            check("step", cur, expv);
            if (steps > 1) check("tick gap", 15'(gap), 15'd8);
            if (steps == 11) check("zero", cur, 15'h0);
            gap = 0;
            prv = cur;
         end
      end
      check("steps", 15'(steps), 15'd12);
      check("expiry pulses", 15'(n_exp), 15'd1);
      // freeze in non-qualifying states, reload on entry
      for (int i = 0; i < 5; i++) begin
         cyc_wait(20);
         line_state = frz_ls[i % 3];
         cyc_wait(2);
         prv = cur;
         cyc_wait(30);
         check("frozen", cur, prv);
         line_state = run_ls[i];
         cyc_wait(1);
         check("entry reload", cur, {7'h02, 8'h03});
      end
      // noise snapshots
      line_state = lsd_pkg::LSD_LS_IDLE;
      wr(5'h0d, 8'h05);
      wr(5'h0e, 8'h83);
      host.access(1'b0, 5'h0f, 8'h00, rd, ak);
      check("noise count", rd[6:0], 7'h05);
      rdc(5'h0f, 8'h05);
      rdc(5'h10, 8'h83);
      wr(5'h10, 8'h11);
      check("reject", write_reject_r, 1'b1);
      rdc(5'h10, 8'h83);
      wr(5'h0f, 8'h7e);
      check("reject", write_reject_r, 1'b1);
      rdc(5'h0f, 8'h05);
      line_state = lsd_pkg::LSD_LS_NOISE;
      cyc_wait(20);
      host.access(1'b0, 5'h10, 8'h00, rd, ak);
      v1 = rd;
      check("noise prescale runs", v1 < 8'h83, 1'b1);
      cyc_wait(10);
      check("snapshot held", cb_rdata_r, v1);
      line_state = lsd_pkg::LSD_LS_ACTIVE;
      cyc_wait(20);
      host.access(1'b0, 5'h10, 8'h00, rd, ak);
      check("no reload", rd < v1, 1'b1);
      rdc(5'h0f, 8'h85);
      // noise pair 1/1 expires every fourth tick
      wr(5'h0d, 8'h01);
      wr(5'h0e, 8'h01);
      n_exp = 0;
      for (int i = 0; i < 70; i++) begin
         cyc_wait(1);
         if (noise_expired_r === 1'b1) n_exp++;
      end
      check("noise expiry pulses", 15'(n_exp), 15'd2);
      end_of_test();
   end
endmodule
